/* File: design/card_host_ctl.sv */
// card host control: mode routing, supply select, power sequencing, axi4-lite regs
//
// Functional notes
// RULE_01: interrupt pin pulled low on fault/presence change
// RULE_02: mode high passes card signals normally
// RULE_03: mode low floats card clock, reset, lines
// RULE_04: mode low joins aux a/DP, aux b/DM
// RULE_05: D+ isolated in card mode, joined otherwise
// RULE_06: mode select idles high, card mode
// RULE_07: mode low opens host aux a path
// RULE_08: mode low opens host aux b path
// RULE_09: two-bit supply select code decoding
// RULE_10: ready only once supply above level
// RULE_11: ready pull-up off when down/deselected
// RULE_12: long button press turns device on
// RULE_13: long press while on, off after handshake
// RULE_14: shutdown request raised after debounced press
// RULE_15: acknowledge powers down, drops main supply
// RULE_16: acknowledge weakly follows shutdown request
// RULE_17: host may pulse button from logic
// RULE_18: card clock passed through while active
// RULE_19: card reset passed through from host
// RULE_20: deselect latches inputs, floats host lines; here only the select and reset bits latch and the host pull-ups stay on
// RULE_21: no activation without card present
// RULE_22: clock and reset low unless ready
// RULE_23: D- goes to aux b, not a
// RULE_24: debounce is a configurable cycle count
//
// Local design decisions: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "card_ctl_cfg.svh"

module card_host_ctl #(
    parameter logic [23:0] DEBOUNCE_CYCLES = 24'(`DEBOUNCE_CYC)
) (
    input  wire logic        CLOCK,             // 125 mhz
    input  wire logic        RESET,             // sync, active high
    input  wire logic [3:0]  S_AXI_AWADDR,      // write address
    input  wire logic        S_AXI_AWVALID,     // write address valid
    output logic             S_AXI_AWREADY,     // write address ready
    input  wire logic [31:0] S_AXI_WDATA,       // write data
    input  wire logic [3:0]  S_AXI_WSTRB,       // byte strobes
    input  wire logic        S_AXI_WVALID,      // write data valid
    output logic             S_AXI_WREADY,      // write data ready
    output logic [1:0]       S_AXI_BRESP,       // write response
    output logic             S_AXI_BVALID,      // write response valid
    input  wire logic        S_AXI_BREADY,      // write response ready
    input  wire logic [3:0]  S_AXI_ARADDR,      // read address
    input  wire logic        S_AXI_ARVALID,     // read address valid
    output logic             S_AXI_ARREADY,     // read address ready
    output logic [31:0]      S_AXI_RDATA,       // read data
    output logic [1:0]       S_AXI_RRESP,       // read response
    output logic             S_AXI_RVALID,      // read data valid
    input  wire logic        S_AXI_RREADY,      // read data ready
    input  wire logic        CARD_MODE_SEL,     // 1 card mode, 0 usb card mode
    input  wire logic        VSEL_HI_N,         // supply select, high bit
    input  wire logic        VSEL_LO_N,         // supply select, low bit
    input  wire logic        CARD_DETECT,       // high while card inserted
    input  wire logic        CHIP_SEL,          // 0 deselects the device
    input  wire logic        PWR_BUTTON_N,      // low while button pressed
    input  wire logic        SHUTDOWN_ACK,      // host grants power-off
    input  wire logic        VCC_ABOVE_LEVEL,   // supply above selected level
    input  wire logic        CARD_CLOCK_SOURCE, // clock from host
    input  wire logic        CARD_RESET_SOURCE, // reset command from host
    input  wire logic [2:0]  HOST_LINE_I,       // host io, aux a, aux b level
    output logic [2:0]       HOST_LINE_O,       // host lines drive value
    output logic [2:0]       HOST_LINE_OE,      // host lines pulled low
    output logic [2:0]       HOST_PULLUP_EN,    // host line pull-ups
    input  wire logic [2:0]  CARD_LINE_I,       // card io, aux a, aux b level
    output logic [2:0]       CARD_LINE_O,       // card lines drive value
    output logic [2:0]       CARD_LINE_OE,      // card lines pulled low
    output logic [2:0]       CARD_PULLUP_EN,    // card line pull-ups
    output logic             CARD_CLK_O,        // card clock
    output logic             CARD_CLK_OE,       // card clock enable
    output logic             CARD_RST_O,        // card reset
    output logic             CARD_RST_OE,       // card reset enable
    output logic             USB_DP_SW_EN,      // joins card aux a to D+
    output logic             USB_DM_SW_EN,      // joins card aux b to D-
    output logic             MODE_PULLUP_EN,    // weak pull-up on mode select
    output logic [1:0]       VCC_LEVEL,         // regulator setting
    output logic             MAIN_SUPPLY_EN,    // device powered
    output logic             INT_N_O,           // interrupt drive value
    output logic             INT_N_OE,          // interrupt pulled low
    output logic             INT_PULLUP_EN,     // interrupt pull-up
    output logic             RDY_N_O,           // ready drive value
    output logic             RDY_N_OE,          // ready pulled low
    output logic             RDY_PULLUP_EN,     // ready pull-up
    output logic             SHUTDOWN_REQ,      // request to power off
    output logic             ACK_BIAS_O         // weak drive onto ack pin
);

    card_ctl_pkg::state_t     r;
    card_ctl_pkg::state_t     next_r;
    card_ctl_pkg::vcc_level_t vsel;
    logic [8:0]               raw;
    logic                     sc_mode;
    logic                     cs;
    logic                     present;
    logic                     pressed;
    logic                     on;
    logic                     card_active;
    logic                     card_ready;
    logic                     press_done;
    logic                     wr_fire;
    logic [31:0]              status;
    logic [31:0]              ctrl_merged;
    logic [31:0]              dbc_merged;

    // active-low select pair, high bit first
    function automatic card_ctl_pkg::vcc_level_t decode_vsel(input logic [8:0] c);
        decode_vsel = card_ctl_pkg::vcc_level_t'({c[`SY_VHI_N], c[`SY_VLO_N]});
    endfunction

    // byte-lane merge for register writes
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  s);
        merge = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                merge[i*8 +: 8] = d[i*8 +: 8];
            end
        end
    endfunction

    assign raw = {CARD_RESET_SOURCE, VCC_ABOVE_LEVEL, CHIP_SEL, SHUTDOWN_ACK,
                  PWR_BUTTON_N, CARD_DETECT, VSEL_LO_N, VSEL_HI_N, CARD_MODE_SEL};

    // decoded levels, all but the power state from the filtered copies
    assign sc_mode     = r.clean[`SY_MODE];
    assign cs          = r.clean[`SY_CS];
    assign present     = r.clean[`SY_DETECT];
    assign pressed     = ~r.clean[`SY_BTN_N];
    assign on          = (r.pwr != card_ctl_pkg::ST_OFF);
    assign vsel        = decode_vsel(r.clean);                     // RULE_09
    // request state forces the card down so the ack can finish the job
    assign card_active = (r.pwr == card_ctl_pkg::ST_ON) && r.act_en
                         && present                                // RULE_21
                         && (vsel != card_ctl_pkg::VCC_NONE);
    assign card_ready  = card_active && r.clean[`SY_VCC_OK];       // RULE_10
    assign press_done  = r.armed && pressed && (r.dbc_cnt >= r.dbc_len); // RULE_24
    assign wr_fire     = r.aw_got && r.w_got && !r.bvalid;

    // byte-lane merges of the held write word into the current register values
    assign ctrl_merged = merge({31'h0000_0000, r.act_en}, r.w_data, r.w_strb);
    assign dbc_merged  = merge({8'h00, r.dbc_len}, r.w_data, r.w_strb);

    assign status = {21'h00_0000, vsel, r.clean[`SY_VCC_OK], card_ready, card_active,
                     present, cs, sc_mode, r.act_en, r.pwr == card_ctl_pkg::ST_REQ, on};

    // next state: filters, power sequencer, events and bus slave
    always_comb begin
        next_r = r;
        // three-stage filter: a change counts once stages two and three agree
        next_r.sync1 = raw;
        next_r.sync2 = r.sync1;
        next_r.sync3 = r.sync2;
        next_r.clean = (~(r.sync2 ^ r.sync3) & r.sync3) | ((r.sync2 ^ r.sync3) & r.clean);
        // while deselected the filtered select and reset bits freeze
        if (!cs) begin                                             // RULE_20
            next_r.clean[`SY_VHI_N] = r.clean[`SY_VHI_N];
            next_r.clean[`SY_VLO_N] = r.clean[`SY_VLO_N];
            next_r.clean[`SY_RST]   = r.clean[`SY_RST];
        end

        // press counter; a press must be released before it can act again
        if (!pressed) begin
            next_r.dbc_cnt = 24'h00_0000;
            next_r.armed   = 1'b1;
        end else if (r.armed && r.dbc_cnt < r.dbc_len) begin
            next_r.dbc_cnt = r.dbc_cnt + 24'h00_0001;
        end

        unique case (r.pwr)
            card_ctl_pkg::ST_OFF: begin
                if (press_done) begin                              // RULE_12
                    next_r.pwr   = card_ctl_pkg::ST_ON;
                    next_r.armed = 1'b0;
                end
            end
            card_ctl_pkg::ST_ON: begin
                if (press_done) begin                              // RULE_14
                    next_r.pwr   = card_ctl_pkg::ST_REQ;
                    next_r.armed = 1'b0;
                end
            end
            card_ctl_pkg::ST_REQ: begin
                // off only after ack and once the card supply has fallen
                if (r.clean[`SY_ACK] && !r.clean[`SY_VCC_OK]) begin // RULE_13 RULE_15
                    next_r.pwr = card_ctl_pkg::ST_OFF;
                end
            end
            default: next_r.pwr = card_ctl_pkg::ST_OFF;
        endcase

        // sticky events; hardware set wins over a software clear
        next_r.card_detect_d    = present;
        next_r.was_ready = card_ready;
        if (wr_fire && r.aw_addr == `REG_EVENT) begin
            next_r.events = r.events & ~r.w_data[1:0];
        end
        if (present != r.card_detect_d) begin                             // RULE_01
            next_r.events[`EVT_CARD_DETECT] = 1'b1;
        end
        if (r.was_ready && card_active && !r.clean[`SY_VCC_OK]) begin
            next_r.events[`EVT_FAULT] = 1'b1;
        end

        // write side: address and data in either order
        if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            next_r.aw_got  = 1'b1;
            next_r.aw_addr = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && S_AXI_WREADY) begin
            next_r.w_got  = 1'b1;
            next_r.w_data = S_AXI_WDATA;
            next_r.w_strb = S_AXI_WSTRB;
        end
        if (wr_fire) begin
            next_r.aw_got = 1'b0;
            next_r.w_got  = 1'b0;
            next_r.bvalid = 1'b1;
            next_r.bresp  = `RESP_OKAY;
            unique case (r.aw_addr)
                `REG_CTRL: begin
                    next_r.act_en = ctrl_merged[`CTRL_ACT_EN];
                end
                `REG_DEBOUNCE: begin
                    next_r.dbc_len = dbc_merged[23:0];
                end
                `REG_STATUS, `REG_EVENT: begin
                end
                default: next_r.bresp = `RESP_SLVERR;
            endcase
        end else if (r.bvalid && S_AXI_BREADY) begin
            next_r.bvalid = 1'b0;
        end

        // read side: one cycle from address to data
        if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            next_r.rvalid = 1'b1;
            next_r.rresp  = `RESP_OKAY;
            unique case (S_AXI_ARADDR)
                `REG_CTRL:     next_r.rdata = {31'h0000_0000, r.act_en};
                `REG_STATUS:   next_r.rdata = status;
                `REG_EVENT:    next_r.rdata = {30'h0000_0000, r.events};
                `REG_DEBOUNCE: next_r.rdata = {8'h00, r.dbc_len};
                default: begin
                    next_r.rdata = 32'h0000_0000;
                    next_r.rresp = `RESP_SLVERR;
                end
            endcase
        end else if (r.rvalid && S_AXI_RREADY) begin
            next_r.rvalid = 1'b0;
        end
    end

    // single state register; the mode filter idles high so a floating pin means card mode
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            r         <= '0;
            r.sync1   <= `SYNC_RST;                                // RULE_06
            r.sync2   <= `SYNC_RST;
            r.sync3   <= `SYNC_RST;
            r.clean   <= `SYNC_RST;
            r.pwr     <= card_ctl_pkg::ST_OFF;
            r.dbc_len <= DEBOUNCE_CYCLES;
        end else begin
            r <= next_r;
        end
    end

    // bus handshakes
    assign S_AXI_AWREADY = !r.aw_got && !r.bvalid;
    assign S_AXI_WREADY  = !r.w_got && !r.bvalid;
    assign S_AXI_BVALID  = r.bvalid;
    assign S_AXI_BRESP   = r.bresp;
    assign S_AXI_ARREADY = !r.rvalid;
    assign S_AXI_RVALID  = r.rvalid;
    assign S_AXI_RDATA   = r.rdata;
    assign S_AXI_RRESP   = r.rresp;

    // data lines: a low on one side is copied to the other; the oe term
    // keeps a line this block itself pulls low from echoing back
    for (genvar i = 0; i < 3; i++) begin : g_line
        logic pass;
        // aux paths open in usb mode, host side cut off while deselected
        assign pass              = sc_mode && cs;                  // RULE_02 RULE_07 RULE_08
        assign CARD_LINE_O[i]    = 1'b0;
        assign HOST_LINE_O[i]    = 1'b0;
        assign CARD_LINE_OE[i]   = pass && !HOST_LINE_I[i] && !HOST_LINE_OE[i]; // RULE_03
        assign HOST_LINE_OE[i]   = pass && !CARD_LINE_I[i] && !CARD_LINE_OE[i]; // RULE_20
        assign CARD_PULLUP_EN[i] = sc_mode;
        assign HOST_PULLUP_EN[i] = 1'b1;
    end

    // card clock passes straight through, reset via its filtered copy; both gated low until ready
    assign CARD_CLK_O  = card_ready && CARD_CLOCK_SOURCE;          // RULE_18 RULE_22
    assign CARD_RST_O  = card_ready && r.clean[`SY_RST];           // RULE_19 RULE_22
    assign CARD_CLK_OE = sc_mode;                                  // RULE_03
    assign CARD_RST_OE = sc_mode;

    // usb switch: D+ to aux a, D- to aux b
    assign USB_DP_SW_EN   = !sc_mode;                              // RULE_04 RULE_05
    assign USB_DM_SW_EN   = !sc_mode;                              // RULE_23
    assign MODE_PULLUP_EN = 1'b1;
    assign VCC_LEVEL      = card_active ? vsel : card_ctl_pkg::VCC_NONE;
    assign MAIN_SUPPLY_EN = on;                                    // RULE_15

    // open-drain status pins go quiet when powered down or deselected
    assign INT_N_O       = 1'b0;
    assign INT_N_OE      = on && cs && (r.events != 2'h0);         // RULE_01
    assign INT_PULLUP_EN = on && cs;
    assign RDY_N_O       = 1'b0;
    assign RDY_N_OE      = on && cs && !card_ready;
    assign RDY_PULLUP_EN = on && cs;                               // RULE_11

    // the ack pin is weakly tied to the request so an idle host still lets it off
    assign SHUTDOWN_REQ = (r.pwr == card_ctl_pkg::ST_REQ);         // RULE_14
    assign ACK_BIAS_O   = SHUTDOWN_REQ;                            // RULE_16

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RESET);

    property p_int_low;
        on && cs && r.events != 2'h0 |-> INT_N_OE && !INT_N_O;
    endproperty
    a_int_low: assert property (p_int_low) else $error("interrupt not low"); // RULE_01

    property p_usb_float;
        !sc_mode |-> !CARD_CLK_OE && !CARD_RST_OE && CARD_LINE_OE == 3'h0;
    endproperty
    a_usb_float: assert property (p_usb_float) else $error("card lines driven"); // RULE_03

    property p_usb_sw;
        USB_DP_SW_EN == !sc_mode && USB_DM_SW_EN == USB_DP_SW_EN;
    endproperty
    a_usb_sw: assert property (p_usb_sw) else $error("usb switch wrong"); // RULE_05

    property p_rdy_level;
        on && cs && !RDY_N_OE |-> vsel != card_ctl_pkg::VCC_NONE && r.clean[`SY_VCC_OK];
    endproperty
    a_rdy_level: assert property (p_rdy_level) else $error("ready too early"); // RULE_10

    property p_turn_on;
        r.pwr == card_ctl_pkg::ST_OFF && press_done |=> r.pwr == card_ctl_pkg::ST_ON;
    endproperty
    a_turn_on: assert property (p_turn_on) else $error("no turn on"); // RULE_12

    property p_req_hold;
        r.pwr == card_ctl_pkg::ST_REQ && !r.clean[`SY_ACK] |=> SHUTDOWN_REQ && MAIN_SUPPLY_EN;
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("off without ack"); // RULE_13

    property p_req_cause;
        $rose(SHUTDOWN_REQ) |-> $past(r.pwr) == card_ctl_pkg::ST_ON && $past(press_done);
    endproperty
    a_req_cause: assert property (p_req_cause) else $error("stray request"); // RULE_14

    property p_clk_low;
        !card_ready |-> !CARD_CLK_O && !CARD_RST_O;
    endproperty
    a_clk_low: assert property (p_clk_low) else $error("clock not held low"); // RULE_22

    property p_no_card;
        !present |-> !card_active;
    endproperty
    a_no_card: assert property (p_no_card) else $error("active with no card"); // RULE_21

    c_power_on: cover property (r.pwr == card_ctl_pkg::ST_OFF ##1 r.pwr == card_ctl_pkg::ST_ON);
    c_shutdown: cover property (SHUTDOWN_REQ ##1 !MAIN_SUPPLY_EN);
    c_ready:    cover property (card_ready && sc_mode);
    c_usb:      cover property (on && !sc_mode);

endmodule

/* File: include/card_ctl_cfg.svh */
// register offsets, field positions, reset values and timing counts
`ifndef CARD_CTL_CFG_SVH
`define CARD_CTL_CFG_SVH

`define REG_CTRL      4'h0
`define REG_STATUS    4'h4
`define REG_EVENT     4'h8
`define REG_DEBOUNCE  4'hC

`define CTRL_ACT_EN   0
`define EVT_CARD_DETECT      0
`define EVT_FAULT     1

`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2

// sync bit positions and their idle levels
`define SY_MODE       0
`define SY_VHI_N      1
`define SY_VLO_N      2
`define SY_DETECT     3
`define SY_BTN_N      4
`define SY_ACK        5
`define SY_CS         6
`define SY_VCC_OK     7
`define SY_RST        8
`define SYNC_RST      9'h057

`define CLK_KHZ       125000
`define DEBOUNCE_MS   10
`define DEBOUNCE_CYC  (`DEBOUNCE_MS * `CLK_KHZ)

`endif

/* File: include/card_ctl_pkg.sv */
// types shared by the card host control block
package card_ctl_pkg;

    typedef enum logic [1:0] {
        ST_OFF = 2'b00,
        ST_ON  = 2'b01,
        ST_REQ = 2'b10
    } pwr_state_t;

    typedef enum logic [1:0] {
        VCC_1V8  = 2'b00,
        VCC_5V0  = 2'b01,
        VCC_3V0  = 2'b10,
        VCC_NONE = 2'b11
    } vcc_level_t;

    typedef struct packed {
        logic [8:0]  sync1;
        logic [8:0]  sync2;
        logic [8:0]  sync3;
        logic [8:0]  clean;
        pwr_state_t  pwr;
        logic        armed;
        logic [23:0] dbc_cnt;
        logic [23:0] dbc_len;
        logic        act_en;
        logic [1:0]  events;
        logic        card_detect_d;
        logic        was_ready;
        logic        aw_got;
        logic [3:0]  aw_addr;
        logic        w_got;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
    } state_t;

endpackage

/* File: sim/card_host_partner.sv */
// far side model: card supply comparator, ack bias pin, open-drain host and card wires
`timescale 1ns/1ps
module card_host_partner (
    input  wire logic       CLOCK,           // bench clock
    input  wire logic       RESET,           // sync, active high
    input  wire logic [1:0] VCC_LEVEL,       // regulator setting from design
    output logic            VCC_ABOVE_LEVEL, // supply comparator
    input  wire logic       ACK_BIAS_O,      // weak bias from request pin
    output logic            SHUTDOWN_ACK,    // resolved ack wire
    input  wire logic [2:0] HOST_LINE_OE,    // design pulls host lines
    input  wire logic [2:0] host_drv,        // host pulls its own lines
    input  wire logic [2:0] card_drv,        // card pulls its own lines
    output logic [2:0]      HOST_LINE_I,     // host wire level
    input  wire logic [2:0] CARD_LINE_OE,    // design pulls card lines
    output logic [2:0]      CARD_LINE_I      // card wire level
);
    logic [3:0] ramp;

    // supply takes four cycles to rise but collapses at once when switched off
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            ramp <= 4'h0;
        end else begin
            ramp <= {ramp[2:0], VCC_LEVEL != 2'h3};
        end
    end
    assign VCC_ABOVE_LEVEL = ramp[3] & (VCC_LEVEL != 2'h3);

    // host leaves ack undriven, so the weak bias from the request decides
    assign SHUTDOWN_ACK = ACK_BIAS_O;

    // wires with pull-ups: low as soon as any party pulls
    assign HOST_LINE_I = ~(HOST_LINE_OE | host_drv);
    assign CARD_LINE_I = ~(CARD_LINE_OE | card_drv);
endmodule

/* File: sim/smart_card_host_control_tb.sv */
// self-checking bench for the card host control block
`timescale 1ns/1ps
module smart_card_host_control_tb;
    logic        CLOCK = 1'b0, RESET = 1'b1;
    logic [3:0]  S_AXI_AWADDR = 4'h0, S_AXI_ARADDR = 4'h0, S_AXI_WSTRB = 4'hF;
    logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA, rd;
    logic        S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b1;
    logic        S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0, seen;
    logic        S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
    logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, VCC_LEVEL, resp;
    logic        CARD_MODE_SEL = 1'b1, VSEL_HI_N = 1'b1, VSEL_LO_N = 1'b1, CARD_DETECT = 1'b1;
    logic        CHIP_SEL = 1'b1, PWR_BUTTON_N = 1'b1;
    logic        CARD_CLOCK_SOURCE = 1'b0, CARD_RESET_SOURCE = 1'b0;
    logic        SHUTDOWN_ACK, VCC_ABOVE_LEVEL, CARD_CLK_O, CARD_CLK_OE, CARD_RST_O, CARD_RST_OE;
    logic        USB_DP_SW_EN, USB_DM_SW_EN, MODE_PULLUP_EN, MAIN_SUPPLY_EN, INT_N_OE;
    logic        INT_PULLUP_EN, RDY_N_OE, RDY_PULLUP_EN, SHUTDOWN_REQ, ACK_BIAS_O;
    logic [2:0]  HOST_LINE_I, HOST_LINE_OE, CARD_LINE_I, CARD_LINE_OE, CARD_PULLUP_EN;
    logic [2:0]  host_drv = 3'h0;
    logic [2:0]  card_drv = 3'h0;
    int          error_cnt = 0, compares = 0, cyc = 0;

    // short debounce keeps the run brief
    card_host_ctl #(.DEBOUNCE_CYCLES(24'h00_0008)) u_dut (.CLOCK, .RESET,
        .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB,
        .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY,
        .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP,
        .S_AXI_RVALID, .S_AXI_RREADY, .CARD_MODE_SEL, .VSEL_HI_N, .VSEL_LO_N, .CARD_DETECT,
        .CHIP_SEL, .PWR_BUTTON_N, .SHUTDOWN_ACK, .VCC_ABOVE_LEVEL, .CARD_CLOCK_SOURCE,
        .CARD_RESET_SOURCE, .HOST_LINE_I, .HOST_LINE_O(), .HOST_LINE_OE, .HOST_PULLUP_EN(),
        .CARD_LINE_I, .CARD_LINE_O(), .CARD_LINE_OE, .CARD_PULLUP_EN, .CARD_CLK_O,
        .CARD_CLK_OE, .CARD_RST_O, .CARD_RST_OE, .USB_DP_SW_EN, .USB_DM_SW_EN,
        .MODE_PULLUP_EN, .VCC_LEVEL, .MAIN_SUPPLY_EN, .INT_N_O(), .INT_N_OE, .INT_PULLUP_EN,
        .RDY_N_O(), .RDY_N_OE, .RDY_PULLUP_EN, .SHUTDOWN_REQ, .ACK_BIAS_O);

    card_host_partner u_far (.CLOCK, .RESET, .VCC_LEVEL, .VCC_ABOVE_LEVEL, .ACK_BIAS_O,
        .SHUTDOWN_ACK, .HOST_LINE_OE, .host_drv, .card_drv, .HOST_LINE_I, .CARD_LINE_OE,
        .CARD_LINE_I);

    always #4 CLOCK = ~CLOCK;

    // watchdog: the whole sequence needs well under a thousand cycles
    always @(posedge CLOCK) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            end_sim();
        end
    end

    task end_sim;
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task tick(input int n);
        repeat (n) @(posedge CLOCK);
    endtask

    // handshakes are judged on values settled at the falling edge before each rising edge
    task wr(input logic [3:0] a, input logic [31:0] d);
        logic aw_ok, w_ok, b_ok;
        S_AXI_AWADDR <= a;
        S_AXI_WDATA <= d;
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WVALID <= 1'b1;
        b_ok = 1'b0;
        while (!b_ok) begin
            @(negedge CLOCK);
            aw_ok = S_AXI_AWREADY & S_AXI_AWVALID;
            w_ok = S_AXI_WREADY & S_AXI_WVALID;
            b_ok = S_AXI_BVALID;
            resp = S_AXI_BRESP;
            @(posedge CLOCK);
            if (aw_ok) S_AXI_AWVALID <= 1'b0;
            if (w_ok) S_AXI_WVALID <= 1'b0;
        end
        chk("bresp", 32'h0, resp);
    endtask

    task rdreg(input logic [3:0] a, output logic [31:0] d);
        logic ar_ok, r_ok;
        S_AXI_ARADDR <= a;
        S_AXI_ARVALID <= 1'b1;
        S_AXI_RREADY <= 1'b1;
        r_ok = 1'b0;
        while (!r_ok) begin
            @(negedge CLOCK);
            ar_ok = S_AXI_ARREADY & S_AXI_ARVALID;
            r_ok = S_AXI_RVALID;
            d = S_AXI_RDATA;
            resp = S_AXI_RRESP;
            @(posedge CLOCK);
            if (ar_ok) S_AXI_ARVALID <= 1'b0;
        end
        S_AXI_RREADY <= 1'b0;
        chk("rresp", 32'h0, resp);
    endtask

    // host pulses the button from a logic output
    task press(input int n);
        PWR_BUTTON_N <= 1'b0;
        tick(n);
        PWR_BUTTON_N <= 1'b1;
        tick(8);
    endtask

    initial begin
        tick(12);
        RESET <= 1'b0;
        tick(4);
        rdreg(4'hC, rd);
        chk("debounce", 32'h0000_0008, rd);
        chk("mode_pullup", 32'h1, MODE_PULLUP_EN);
        press(4);
        chk("main_short", 32'h0, MAIN_SUPPLY_EN);
        press(20);
        chk("main_on", 32'h1, MAIN_SUPPLY_EN);
        wr(4'h0, 32'h1);
        wr(4'h8, 32'h3);
        tick(2);
        chk("int_clear", 32'h0, INT_N_OE);
        for (int k = 0; k < 4; k++) begin
            VSEL_HI_N <= k[1];
            VSEL_LO_N <= k[0];
            tick(16);
            chk("vcc_level", 32'(k), VCC_LEVEL);
            chk("rdy_low", 32'(k == 3), RDY_N_OE);
        end
        VSEL_HI_N <= 1'b0;
        CARD_RESET_SOURCE <= 1'b1;
        tick(16);
        chk("rst_pass", 32'h1, CARD_RST_O);
        CARD_CLOCK_SOURCE <= 1'b1;
        tick(1);
        chk("clk_pass", 32'h1, CARD_CLK_O);
        host_drv <= 3'h7;
        tick(2);
        chk("card_lines", 32'h7, CARD_LINE_OE);
        CARD_MODE_SEL <= 1'b0;
        tick(6);
        chk("clk_oe", 32'h0, CARD_CLK_OE);
        chk("rst_oe", 32'h0, CARD_RST_OE);
        chk("card_lines_usb", 32'h0, CARD_LINE_OE);
        chk("card_pullup", 32'h0, CARD_PULLUP_EN);
        chk("dp_on", 32'h1, USB_DP_SW_EN);
        chk("dm_on", 32'h1, USB_DM_SW_EN);
        CARD_MODE_SEL <= 1'b1;
        host_drv <= 3'h0;
        CARD_CLOCK_SOURCE <= 1'b0;
        tick(6);
        chk("dp_off", 32'h0, USB_DP_SW_EN);
        card_drv <= 3'h7;
        tick(2);
        chk("host_lines", 32'h7, HOST_LINE_OE);
        card_drv <= 3'h0;
        wr(4'h8, 32'h3);
        CARD_DETECT <= 1'b0;
        tick(8);
        chk("vcc_no_card", 32'h3, VCC_LEVEL);
        chk("rst_held", 32'h0, CARD_RST_O);
        chk("int_card_detect", 32'h1, INT_N_OE);
        CARD_DETECT <= 1'b1;
        tick(12);
        wr(4'h8, 32'h3);
        tick(2);
        chk("int_w1c", 32'h0, INT_N_OE);
        CHIP_SEL <= 1'b0;
        tick(6);
        VSEL_HI_N <= 1'b1;
        tick(8);
        chk("int_pullup", 32'h0, INT_PULLUP_EN);
        chk("rdy_pullup", 32'h0, RDY_PULLUP_EN);
        chk("vsel_frozen", 32'h1, VCC_LEVEL);
        CHIP_SEL <= 1'b1;
        tick(8);
        chk("vsel_follow", 32'h3, VCC_LEVEL);
        VSEL_HI_N <= 1'b0;
        tick(12);
        PWR_BUTTON_N <= 1'b0;
        seen = 1'b0;
        repeat (30) begin
            @(negedge CLOCK);
            if (SHUTDOWN_REQ === 1'b1) seen = 1'b1;
        end
        chk("shutdown_req", 32'h1, seen);
        @(posedge CLOCK);
        PWR_BUTTON_N <= 1'b1;
        tick(20);
        chk("main_off", 32'h0, MAIN_SUPPLY_EN);
        end_sim();
    end
endmodule
